// File: rtl/hie_regs.sv
// Interrupt-enable, identity, scratch and software-reset registers.
// Assumes single-cycle command strobes from the processor interface on mclk.
//
// Notes on behaviour
// - Enable bit 6 passes clock-ready event
// - Enable bit 5 passes host-suspended event
// - Stop SOF once all downstream suspended
// - Enable bit 4 passes operational register interrupt
// - Enable bit 2 passes transfer-end event
// - Enable bit 1 passes async-list event
// - Enable bit 0 passes frame-start event
// - Identity read-only at 27, product high byte
// - Identity low byte is revision number
// - Scratch word read 28, write A8
// - Key resets core registers, buffer kept
// - Enables combine with hardware-config bit 0
// - Zero enables mean no interrupt output
// - Enable register read 25, write A5
`timescale 1ns/1ps
module hie_regs (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic cmdValid,
  input wire logic [7:0] cmdCode,
  input wire logic [15:0] wrData,
  output logic [15:0] rdData,
  output logic rdValid,
  input wire logic [6:0] irqStatus,
  input wire logic hwIrqGlobalEnable,
  input wire logic allDownstreamSuspended,
  input wire logic sofRequest,
  output logic sofEmit,
  output logic hostCoreReset,
  output logic hostIrqPin
);
  typedef struct packed {
    logic [15:0] irqEn;
    logic [15:0] scratch;
    logic [15:0] rdData;
    logic rdValid;
    logic coreReset;
    hie_pkg::hie_rst_state_t rstState;
  } hie_state_t;

  hie_state_t st_r;
  hie_state_t st_nxt;
  logic keyHit;
  logic irqReq;
  logic readCmd;

  assign keyHit = cmdValid && cmdCode == hie_pkg::CMD_SOFT_RST_WR
    && wrData == hie_pkg::SOFT_RST_KEY;

  // Any read code; only the checks below look at it
  assign readCmd = cmdValid && (cmdCode == hie_pkg::CMD_IRQ_EN_RD
    || cmdCode == hie_pkg::CMD_ID_RD || cmdCode == hie_pkg::CMD_SCRATCH_RD);

  always_comb begin
    st_nxt = st_r;
    st_nxt.rdValid = 1'b0;
    st_nxt.coreReset = 1'b0;
    st_nxt.rstState = hie_pkg::SR_IDLE;
    if (cmdValid) begin
      case (cmdCode)
        hie_pkg::CMD_IRQ_EN_WR: begin
          st_nxt.irqEn = wrData & hie_pkg::IRQ_EN_MASK;
        end
        hie_pkg::CMD_IRQ_EN_RD: begin
          st_nxt.rdData = st_r.irqEn;
          st_nxt.rdValid = 1'b1;
        end
        hie_pkg::CMD_ID_RD: begin
          st_nxt.rdData = {hie_pkg::PRODUCT_CODE,
            hie_pkg::REVISION_CODE};
          st_nxt.rdValid = 1'b1;
        end
        hie_pkg::CMD_SCRATCH_WR: begin
          st_nxt.scratch = wrData;
        end
        hie_pkg::CMD_SCRATCH_RD: begin
          st_nxt.rdData = st_r.scratch;
          st_nxt.rdValid = 1'b1;
        end
        default: begin
          st_nxt.rdValid = 1'b0;
        end
      endcase
    end
    // Key write clears registers; buffer memory lives elsewhere, untouched
    if (keyHit) begin
      st_nxt.irqEn = hie_pkg::IRQ_EN_RESET;
      st_nxt.scratch = hie_pkg::SCRATCH_RESET;
      st_nxt.rdData = 16'h0000;
      st_nxt.rdValid = 1'b0;
      st_nxt.coreReset = 1'b1;
      st_nxt.rstState = hie_pkg::SR_PULSE;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_r.irqEn <= hie_pkg::IRQ_EN_RESET;
      st_r.scratch <= hie_pkg::SCRATCH_RESET;
      st_r.rdData <= 16'h0000;
      st_r.rdValid <= 1'b0;
      st_r.coreReset <= 1'b0;
      st_r.rstState <= hie_pkg::SR_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  hie_irq_gate u_gate (
    .statusBits(irqStatus),
    .enableBits(st_r.irqEn[6:0]),
    .globalEnable(hwIrqGlobalEnable),
    .irqRequest(irqReq)
  );

  assign hostIrqPin = irqReq;
  assign rdData = st_r.rdData;
  assign rdValid = st_r.rdValid;
  assign hostCoreReset = st_r.coreReset;
  // Suspend entry itself is driven by the control register elsewhere
  assign sofEmit = sofRequest & ~allDownstreamSuspended;

  // Assertions
  irq_en_zero_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (st_r.irqEn == 16'h0000) |-> !hostIrqPin)
    else $error("interrupt with all enables clear");
  irq_cause_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    hostIrqPin |-> hwIrqGlobalEnable && |(irqStatus & st_r.irqEn[6:0]))
    else $error("interrupt without enabled cause");
  pin_gate_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    !hwIrqGlobalEnable |-> !hostIrqPin)
    else $error("interrupt with global enable clear");
  // One status bit at a time, so a crossed enable wire shows up
  clk_rdy_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (hwIrqGlobalEnable && irqStatus == 7'h40 && st_r.irqEn[6])
    |-> hostIrqPin)
    else $error("clock ready not passed");
  susp_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (hwIrqGlobalEnable && irqStatus == 7'h20 && st_r.irqEn[5])
    |-> hostIrqPin)
    else $error("suspended not passed");
  opr_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (hwIrqGlobalEnable && irqStatus == 7'h10 && !st_r.irqEn[4])
    |-> !hostIrqPin)
    else $error("operational passed while masked");
  opr_pass_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (hwIrqGlobalEnable && irqStatus == 7'h10 && st_r.irqEn[4])
    |-> hostIrqPin)
    else $error("operational not passed");
  xfer_end_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (hwIrqGlobalEnable && irqStatus == 7'h04 && st_r.irqEn[2])
    |-> hostIrqPin)
    else $error("transfer end not passed");
  async_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (hwIrqGlobalEnable && irqStatus == 7'h02 && st_r.irqEn[1])
    |-> hostIrqPin)
    else $error("async list not passed");
  sof_irq_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (hwIrqGlobalEnable && irqStatus == 7'h01 && st_r.irqEn[0])
    |-> hostIrqPin)
    else $error("frame start not passed");
  sof_stop_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    allDownstreamSuspended |-> !sofEmit)
    else $error("SOF while all suspended");
  sof_pass_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (sofRequest && !allDownstreamSuspended) |-> sofEmit)
    else $error("SOF dropped while ports active");
  id_read_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (cmdValid && cmdCode == hie_pkg::CMD_ID_RD && !keyHit) |=>
    rdValid && rdData == {hie_pkg::PRODUCT_CODE, hie_pkg::REVISION_CODE})
    else $error("identity read wrong");
  rd_valid_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    rdValid == $past(readCmd))
    else $error("read strobe not one cycle after read");
  rd_hold_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (!readCmd && !keyHit) |=> $stable(rdData))
    else $error("read data moved without a read");
  scratch_rt_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (cmdValid && cmdCode == hie_pkg::CMD_SCRATCH_WR) ##1
    (cmdValid && cmdCode == hie_pkg::CMD_SCRATCH_RD)
    |=> rdData == $past(wrData, 2))
    else $error("scratch round trip failed");
  scratch_read_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (cmdValid && cmdCode == hie_pkg::CMD_SCRATCH_RD)
    |=> rdData == $past(st_r.scratch))
    else $error("scratch read wrong");
  scratch_keep_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (!(cmdValid && cmdCode == hie_pkg::CMD_SCRATCH_WR) && !keyHit)
    |=> $stable(st_r.scratch))
    else $error("scratch changed without a write");
  en_rt_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (cmdValid && cmdCode == hie_pkg::CMD_IRQ_EN_WR) ##1
    (cmdValid && cmdCode == hie_pkg::CMD_IRQ_EN_RD)
    |=> rdData == ($past(wrData, 2) & hie_pkg::IRQ_EN_MASK))
    else $error("enable round trip failed");
  en_read_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (cmdValid && cmdCode == hie_pkg::CMD_IRQ_EN_RD)
    |=> rdData == $past(st_r.irqEn))
    else $error("enable read wrong");
  en_keep_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (!(cmdValid && cmdCode == hie_pkg::CMD_IRQ_EN_WR) && !keyHit)
    |=> $stable(st_r.irqEn))
    else $error("enables changed without a write");
  // Reserved bits must never be stored, or they would read back
  en_mask_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    st_r.irqEn == (st_r.irqEn & hie_pkg::IRQ_EN_MASK))
    else $error("reserved enable bit stored");
  key_rst_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    keyHit |=> hostCoreReset && st_r.irqEn == 16'h0000
    && st_r.scratch == 16'h0000)
    else $error("key did not reset");
  core_rst_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    hostCoreReset == $past(keyHit))
    else $error("core reset pulse not tied to key");
  rst_state_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    hostCoreReset == (st_r.rstState == hie_pkg::SR_PULSE))
    else $error("reset state and pulse disagree");
  bad_key_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (cmdValid && cmdCode == hie_pkg::CMD_SOFT_RST_WR && !keyHit)
    |=> !hostCoreReset && $stable(st_r.scratch))
    else $error("non-key reset write acted");
endmodule // hie_regs

// File: rtl/hie_pkg.sv
// Package for the host interrupt-enable and miscellaneous register bank.
// Assumes a command-code register port driven by the processor interface.
package hie_pkg;
  // Command codes
  localparam logic [7:0] CMD_IRQ_EN_RD = 8'h25;
  localparam logic [7:0] CMD_IRQ_EN_WR = 8'hA5;
  localparam logic [7:0] CMD_ID_RD = 8'h27;
  localparam logic [7:0] CMD_SCRATCH_RD = 8'h28;
  localparam logic [7:0] CMD_SCRATCH_WR = 8'hA8;
  localparam logic [7:0] CMD_SOFT_RST_WR = 8'hA9;
  // Interrupt-enable field positions
  localparam int SOF_BIT = 0;
  localparam int ASYNC_BIT = 1;
  localparam int XFER_END_BIT = 2;
  localparam int OPR_BIT = 4;
  localparam int SUSP_BIT = 5;
  localparam int CLK_RDY_BIT = 6;
  localparam logic [15:0] IRQ_EN_MASK = 16'h0077;
  // Reset values
  localparam logic [15:0] IRQ_EN_RESET = 16'h0000;
  localparam logic [15:0] SCRATCH_RESET = 16'h0000;
  localparam logic [15:0] SOFT_RST_KEY = 16'h00F6;
  // Identity: arbitrary neutral values
  localparam logic [7:0] PRODUCT_CODE = 8'hA5;
  localparam logic [7:0] REVISION_CODE = 8'h01;
  typedef enum logic [1:0] {SR_IDLE, SR_PULSE} hie_rst_state_t;
endpackage

// File: rtl/hie_irq_gate.sv
// Gates the seven interrupt status bits by their enables and global enable.
// Assumes status and enables are on mclk.
`timescale 1ns/1ps
module hie_irq_gate (
  input wire logic [6:0] statusBits,
  input wire logic [6:0] enableBits,
  input wire logic globalEnable,
  output logic irqRequest
);
  logic [6:0] gated;
  genvar i;
  generate
    for (i = 0; i < 7; i++) begin : g_bit
      assign gated[i] = statusBits[i] & enableBits[i];
    end
  endgenerate
  // Bit 3 enable is forced zero upstream, so it never contributes
  assign irqRequest = globalEnable & (|gated);
endmodule // hie_irq_gate

// File: testbench/hie_cpu_model.sv
// Processor-side model issuing command cycles to the register bank.
// Assumes mclk from the bench; requests change on the falling edge.
`timescale 1ns/1ps
module hie_cpu_model (
  input wire logic mclk,
  output logic cmdValid,
  output logic [7:0] cmdCode,
  output logic [15:0] wrData
);
  initial begin
    cmdValid = 1'b0;
    cmdCode = 8'h00;
    wrData = 16'h0000;
  end
  // One-cycle strobe; code and data inverted after, never left stale
  task automatic cmd(input logic [7:0] code, input logic [15:0] data);
    @(negedge mclk);
    cmdValid = 1'b1;
    cmdCode = code;
    wrData = data;
    @(negedge mclk);
    cmdValid = 1'b0;
    cmdCode = ~code;
    wrData = ~data;
  endtask
  // Two commands back to back, strobe held high across both
  task automatic cmdPair(input logic [7:0] codeA, input logic [15:0] dataA,
    input logic [7:0] codeB, input logic [15:0] dataB);
    @(negedge mclk);
    cmdValid = 1'b1;
    cmdCode = codeA;
    wrData = dataA;
    @(negedge mclk);
    cmdCode = codeB;
    wrData = dataB;
    @(negedge mclk);
    cmdValid = 1'b0;
    cmdCode = ~codeB;
    wrData = ~dataB;
  endtask
  // DMA set-up order after a frame interrupt lies outside this bank
endmodule // hie_cpu_model

// File: testbench/test_hie_regs.sv
// Self-checking bench for the interrupt-enable and misc register bank.
// Assumes the processor model drives commands; status inputs from here.
`timescale 1ns/1ps
module test_hie_regs;
  logic mclk = 1'b0;
  logic sysRst = 1'b1;
  logic [6:0] irqStatus = 7'h00;
  logic globalEn = 1'b0;
  logic allSusp = 1'b0;
  logic sofReq = 1'b0;
  logic cmdValid, rdValid, sofEmit, hostCoreReset, hostIrqPin;
  logic [7:0] cmdCode;
  logic [15:0] wrData, rdData;
  int mismatches = 0;
  int testsRun = 0;
  hie_cpu_model cpu (.mclk(mclk), .cmdValid(cmdValid), .cmdCode(cmdCode),
    .wrData(wrData));
  hie_regs dut (.mclk(mclk), .sys_rst(sysRst), .cmdValid(cmdValid),
    .cmdCode(cmdCode), .wrData(wrData), .rdData(rdData), .rdValid(rdValid),
    .irqStatus(irqStatus), .hwIrqGlobalEnable(globalEn),
    .allDownstreamSuspended(allSusp), .sofRequest(sofReq),
    .sofEmit(sofEmit), .hostCoreReset(hostCoreReset),
    .hostIrqPin(hostIrqPin));
  initial forever #10 mclk = ~mclk;
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    testsRun++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    check({15'h0000, got}, {15'h0000, exp});
  endtask
  // Answer stands in the cycle after the taking edge
  task automatic rd(input logic [7:0] code, input logic [15:0] exp);
    cpu.cmd(code, 16'h0000);
    chk1(rdValid, 1'b1);
    check(rdData, exp);
  endtask
  task automatic printVerdict;
    $display("checks %0d mismatches %0d", testsRun, mismatches);
    if (mismatches == 0 && testsRun > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    mismatches++;
    printVerdict();
  end
  initial begin
    repeat (12) @(negedge mclk);
    sysRst = 1'b0;
    irqStatus = 7'h7F;
    globalEn = 1'b1;
    rd(hie_pkg::CMD_IRQ_EN_RD, hie_pkg::IRQ_EN_RESET);
    chk1(hostIrqPin, 1'b0);
    rd(hie_pkg::CMD_SCRATCH_RD, hie_pkg::SCRATCH_RESET);
    rd(hie_pkg::CMD_ID_RD,
      {hie_pkg::PRODUCT_CODE, hie_pkg::REVISION_CODE});
    cpu.cmd(hie_pkg::CMD_IRQ_EN_WR, 16'hFFFF);
    rd(hie_pkg::CMD_IRQ_EN_RD, 16'h0077);
    irqStatus = 7'h08;
    #1 chk1(hostIrqPin, 1'b0);
    for (int b = 0; b < 7; b++) begin
      if (b == 3) continue;
      cpu.cmd(hie_pkg::CMD_IRQ_EN_WR, 16'h0001 << b);
      irqStatus = ~(7'h01 << b);
      #1 chk1(hostIrqPin, 1'b0);
      irqStatus = 7'h01 << b;
      globalEn = 1'b0;
      #1 chk1(hostIrqPin, 1'b0);
      globalEn = 1'b1;
      #1 chk1(hostIrqPin, 1'b1);
    end
    irqStatus = 7'h10;
    sofReq = 1'b1;
    #1 chk1(sofEmit, 1'b1);
    chk1(hostIrqPin, 1'b0);
    @(negedge mclk);
    // Stands in for suspend reached through the control register
    allSusp = 1'b1;
    #1 chk1(sofEmit, 1'b0);
    irqStatus = 7'h40;
    #1 chk1(hostIrqPin, 1'b1);
    cpu.cmd(hie_pkg::CMD_SCRATCH_WR, 16'h5AC3);
    rd(hie_pkg::CMD_SCRATCH_RD, 16'h5AC3);
    cpu.cmd(hie_pkg::CMD_SOFT_RST_WR, 16'h00F7);
    chk1(hostCoreReset, 1'b0);
    cpu.cmd(hie_pkg::CMD_SOFT_RST_WR, 16'h01F6);
    chk1(hostCoreReset, 1'b0);
    rd(hie_pkg::CMD_SCRATCH_RD, 16'h5AC3);
    cpu.cmd(hie_pkg::CMD_SOFT_RST_WR, hie_pkg::SOFT_RST_KEY);
    chk1(hostCoreReset, 1'b1);
    chk1(hostIrqPin, 1'b0);
    rd(hie_pkg::CMD_IRQ_EN_RD, 16'h0000);
    rd(hie_pkg::CMD_SCRATCH_RD, 16'h0000);
    cpu.cmdPair(hie_pkg::CMD_SCRATCH_WR, 16'hC35A,
      hie_pkg::CMD_SCRATCH_RD, 16'h0000);
    chk1(rdValid, 1'b1);
    check(rdData, 16'hC35A);
    cpu.cmdPair(hie_pkg::CMD_IRQ_EN_WR, 16'hFFAA,
      hie_pkg::CMD_IRQ_EN_RD, 16'h0000);
    chk1(rdValid, 1'b1);
    check(rdData, 16'h0022);
    irqStatus = 7'h7F;
    #1 chk1(hostIrqPin, 1'b1);
    // Mid-run reset must bring back the power-up values
    @(negedge mclk);
    sysRst = 1'b1;
    repeat (2) @(negedge mclk);
    sysRst = 1'b0;
    #1 chk1(hostIrqPin, 1'b0);
    rd(hie_pkg::CMD_IRQ_EN_RD, hie_pkg::IRQ_EN_RESET);
    rd(hie_pkg::CMD_SCRATCH_RD, hie_pkg::SCRATCH_RESET);
    printVerdict();
  end
endmodule // test_hie_regs
